// ### rtl/pwm_pkg.sv
// Shared constants and types for the ten-bit PWM generator
package pwm_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_DUTY_HI = 8'h04;
	localparam logic [7:0] OFS_DUTY_LO = 8'h08;
	localparam logic [7:0] OFS_PERIOD = 8'h0c;
	localparam logic [7:0] OFS_TMR_CTRL = 8'h10;
	localparam logic [7:0] OFS_TMR_COUNT = 8'h14;
	localparam logic [7:0] OFS_FLAGS = 8'h18;
	localparam logic [7:0] OFS_PIN = 8'h1c;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_EN_BIT = 7;
	localparam int CTRL_OUT_BIT = 5;
	localparam int CTRL_POL_BIT = 4;
	localparam int DUTY_LO_MSB = 7;
	localparam int DUTY_LO_LSB = 6;
	localparam int TMR_RUN_BIT = 2;
	localparam int TMR_PRE_MSB = 1;
	localparam int FLAG_MATCH_BIT = 0;
	localparam int PIN_DIR_BIT = 0;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] DUTY_RST = 8'h00;
	localparam logic [7:0] PERIOD_RST = 8'hff;
	localparam logic [7:0] TMR_RST = 8'h00;
	localparam logic PIN_DIR_RST = 1'b1;

	// ----------------------------------------------------------------
	// Timing: clocks per timer step is 4 times the prescale value
	// ----------------------------------------------------------------
	localparam int Q_CYCLES = 4;
	localparam logic [7:0] PRE1_LAST = 8'(Q_CYCLES * 1 - 1);
	localparam logic [7:0] PRE4_LAST = 8'(Q_CYCLES * 4 - 1);
	localparam logic [7:0] PRE16_LAST = 8'(Q_CYCLES * 16 - 1);
	localparam logic [7:0] PRE64_LAST = 8'(Q_CYCLES * 64 - 1);

	typedef enum logic [1:0] {
		PRE_1 = 2'b00,
		PRE_4 = 2'b01,
		PRE_16 = 2'b10,
		PRE_64 = 2'b11
	} prescale_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_ACTIVE = 2'b10
	} pwm_state_t;

	typedef struct packed {
		logic en;
		logic pol;
	} ctrl_t;

	typedef struct packed {
		logic run;
		prescale_t pre;
	} tmr_ctrl_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] addr;
	} ahb_req_t;

endpackage

// ### rtl/pwm_sync.sv
// Two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module pwm_sync (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic d,
	output logic q
);
	logic meta_reg;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			meta_reg <= 1'b0;
			q <= 1'b0;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// ### rtl/pwm_prescaler.sv
// Timer prescaler: step tick and the two low time-base bits
`timescale 1ns/1ps
`default_nettype none
module pwm_prescaler
	import pwm_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic run,
	input wire logic hold,
	input wire prescale_t sel,
	output logic tick,
	output logic [1:0] phase
);
	logic [7:0] cnt_reg;
	logic [7:0] last;

	always_comb begin
		case (sel)
			PRE_1: last = PRE1_LAST;
			PRE_4: last = PRE4_LAST;
			PRE_16: last = PRE16_LAST;
			default: last = PRE64_LAST;
		endcase
	end

	// Counts system clocks only, so the rate follows the clock
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cnt_reg <= 8'h00;
		end else if (!run) begin
			cnt_reg <= 8'h00;
		end else if (!hold) begin
			cnt_reg <= (cnt_reg >= last) ? 8'h00 : cnt_reg + 8'h01;
		end
	end

	assign tick = run && !hold && (cnt_reg >= last);

	// Clock phase at 1:1, upper prescaler bits otherwise
	always_comb begin
		case (sel)
			PRE_1: phase = cnt_reg[1:0];
			PRE_4: phase = cnt_reg[3:2];
			PRE_16: phase = cnt_reg[5:4];
			default: phase = cnt_reg[7:6];
		endcase
	end
endmodule
`default_nettype wire

// ### rtl/pwm_top.sv
// Ten-bit PWM generator with AHB-Lite register access
//
// Design decisions made here: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module pwm_top
	import pwm_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic RST_B,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic SLEEP_REQ,
	output logic PWM_OUT,
	output logic PWM_OE_B
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	ahb_req_t req_reg;
	ctrl_t ctrl_reg;
	tmr_ctrl_t tmr_ctrl_reg;
	pwm_state_t state_reg;
	logic [7:0] duty_hi_reg;
	logic [1:0] duty_lo_reg;
	logic [7:0] period_reg;
	logic [7:0] tmr_reg;
	logic [9:0] duty_lat_reg;
	logic match_flag_reg;
	logic pin_dir_reg;
	logic accept;
	logic wr_en;
	logic [7:0] wdata;
	logic [31:0] rd_mux;
	logic asleep;
	logic tick;
	logic [1:0] phase;
	logic roll;
	logic [9:0] duty_buf;
	logic [9:0] timebase;
	logic pulse_on;

	// ----------------------------------------------------------------
	// AHB-Lite slave, zero wait states
	// ----------------------------------------------------------------
	// HSIZE is not checked: only whole-word transfers are expected.
	assign accept = HSEL && HREADY && HTRANS[1];
	assign wr_en = req_reg.valid && req_reg.write;
	assign wdata = HWDATA[7:0];

	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			req_reg <= '0;
		end else if (HREADY) begin
			req_reg.valid <= accept;
			req_reg.write <= HWRITE;
			req_reg.addr <= HADDR[7:0];
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (HADDR[7:0])
			OFS_CTRL: begin
				rd_mux[CTRL_EN_BIT] = ctrl_reg.en;
				rd_mux[CTRL_OUT_BIT] = PWM_OUT;
				rd_mux[CTRL_POL_BIT] = ctrl_reg.pol;
			end
			OFS_DUTY_HI: rd_mux[7:0] = duty_hi_reg;
			OFS_DUTY_LO: rd_mux[DUTY_LO_MSB:DUTY_LO_LSB] = duty_lo_reg;
			OFS_PERIOD: rd_mux[7:0] = period_reg;
			OFS_TMR_CTRL: rd_mux[TMR_RUN_BIT:0] = tmr_ctrl_reg;
			OFS_TMR_COUNT: rd_mux[7:0] = tmr_reg;
			OFS_FLAGS: rd_mux[FLAG_MATCH_BIT] = match_flag_reg;
			OFS_PIN: rd_mux[PIN_DIR_BIT] = pin_dir_reg;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Read data is sampled in the address phase; writes land at the end
	// of their data phase, so single transfers never see stale values.
	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			HRDATA <= 32'h0000_0000;
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end else begin
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
			if (accept && !HWRITE) begin
				HRDATA <= rd_mux;
			end
		end
	end

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			ctrl_reg <= '0;
			tmr_ctrl_reg <= '{run: 1'b0, pre: PRE_1};
			pin_dir_reg <= PIN_DIR_RST;
		end else if (wr_en) begin
			case (req_reg.addr)
				OFS_CTRL: begin
					ctrl_reg.en <= wdata[CTRL_EN_BIT];
					ctrl_reg.pol <= wdata[CTRL_POL_BIT];
				end
				OFS_TMR_CTRL: begin
					tmr_ctrl_reg.run <= wdata[TMR_RUN_BIT];
					tmr_ctrl_reg.pre <= prescale_t'(wdata[TMR_PRE_MSB:0]);
				end
				OFS_PIN: pin_dir_reg <= wdata[PIN_DIR_BIT];
				default: ;
			endcase
		end
	end

	// Duty and period buffers may be written at any time
	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			duty_hi_reg <= DUTY_RST;
			duty_lo_reg <= 2'b00;
			period_reg <= PERIOD_RST;
		end else if (wr_en) begin
			case (req_reg.addr)
				OFS_DUTY_HI: duty_hi_reg <= wdata;
				OFS_DUTY_LO: duty_lo_reg <= wdata[DUTY_LO_MSB:DUTY_LO_LSB];
				OFS_PERIOD: period_reg <= wdata;
				default: ;
			endcase
		end
	end

	// Match flag: write one to clear; a new match in the same cycle wins
	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			match_flag_reg <= 1'b0;
		end else if (roll) begin
			match_flag_reg <= 1'b1;
		end else if (wr_en && req_reg.addr == OFS_FLAGS &&
				wdata[FLAG_MATCH_BIT]) begin
			match_flag_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Sleep and timer
	// ----------------------------------------------------------------
	pwm_sync u_sleep_sync (
		.clk(REF_CLK),
		.rst_b(RST_B),
		.d(SLEEP_REQ),
		.q(asleep)
	);

	// Prescaler holds its count in sleep, so the timer resumes
	pwm_prescaler u_prescaler (
		.clk(REF_CLK),
		.rst_b(RST_B),
		.run(tmr_ctrl_reg.run),
		.hold(asleep),
		.sel(tmr_ctrl_reg.pre),
		.tick(tick),
		.phase(phase)
	);

	assign roll = tick && (tmr_reg == period_reg);

	// One step per 4 x prescale clocks, period_reg + 1 steps
	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			tmr_reg <= TMR_RST;
		end else if (roll) begin
			tmr_reg <= TMR_RST;
		end else if (tick) begin
			tmr_reg <= tmr_reg + 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// Duty latch and output
	// ----------------------------------------------------------------
	assign duty_buf = {duty_hi_reg, duty_lo_reg};
	// Full ten bits only at period 255; shorter periods cut it
	assign timebase = {tmr_reg, phase};
	assign pulse_on = state_reg == ST_ACTIVE && timebase != duty_lat_reg;

	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			duty_lat_reg <= 10'h000;
		end else if (roll) begin
			duty_lat_reg <= duty_buf;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			state_reg <= ST_IDLE;
		end else if (!ctrl_reg.en) begin
			state_reg <= ST_IDLE;
		end else if (!asleep) begin
			if (roll) begin
				// Zero duty never sets the output
				state_reg <= (duty_buf != 10'h000) ? ST_ACTIVE : ST_IDLE;
			end else begin
				case (state_reg)
					// A duty beyond the period never matches
					ST_ACTIVE: begin
						if (timebase == duty_lat_reg) begin
							state_reg <= ST_IDLE;
						end
					end
					default: state_reg <= ST_IDLE;
				endcase
			end
		end
	end

	// Idle level equals polarity; PWM_OUT frozen while asleep, PWM_OE_B still follows pin_dir_reg
	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			PWM_OUT <= 1'b0;
			PWM_OE_B <= 1'b1;
		end else begin
			PWM_OE_B <= pin_dir_reg;
			if (!asleep) begin
				PWM_OUT <= ctrl_reg.pol ^ pulse_on;
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_idle_when_off;
		@(posedge REF_CLK) disable iff (!RST_B)
		(!ctrl_reg.en && !asleep) ##1 !asleep
			|=> PWM_OUT == $past(ctrl_reg.pol);
	endproperty
	a_idle_when_off: assert property (p_idle_when_off)
		else $error("output not idle while disabled");

	property p_roll_clears;
		@(posedge REF_CLK) disable iff (!RST_B)
		(tick && tmr_reg == period_reg) |=> tmr_reg == 8'h00;
	endproperty
	a_roll_clears: assert property (p_roll_clears)
		else $error("timer not cleared at period match");

	property p_timer_steps;
		@(posedge REF_CLK) disable iff (!RST_B)
		(tick && tmr_reg != period_reg) |=> tmr_reg == $past(tmr_reg) + 8'h01;
	endproperty
	a_timer_steps: assert property (p_timer_steps)
		else $error("timer did not advance by one");

	property p_start_active;
		@(posedge REF_CLK) disable iff (!RST_B)
		(roll && ctrl_reg.en && duty_buf != 10'h000) |=> state_reg == ST_ACTIVE;
	endproperty
	a_start_active: assert property (p_start_active)
		else $error("period did not start active");

	property p_zero_duty;
		@(posedge REF_CLK) disable iff (!RST_B)
		(roll && duty_buf == 10'h000) |=> state_reg == ST_IDLE ##2
			PWM_OUT == $past(ctrl_reg.pol) || $past(asleep);
	endproperty
	a_zero_duty: assert property (p_zero_duty)
		else $error("zero duty set the output");

	property p_latch_at_roll;
		@(posedge REF_CLK) disable iff (!RST_B)
		!$stable(duty_lat_reg) |-> $past(roll);
	endproperty
	a_latch_at_roll: assert property (p_latch_at_roll)
		else $error("duty latch changed outside rollover");

	property p_end_pulse;
		@(posedge REF_CLK) disable iff (!RST_B)
		(state_reg == ST_ACTIVE && !roll && !asleep &&
			timebase == duty_lat_reg) |=> state_reg == ST_IDLE;
	endproperty
	a_end_pulse: assert property (p_end_pulse)
		else $error("pulse did not end at duty match");

	property p_sleep_freeze;
		@(posedge REF_CLK) disable iff (!RST_B)
		asleep |=> $stable(tmr_reg) && $stable(PWM_OUT);
	endproperty
	a_sleep_freeze: assert property (p_sleep_freeze)
		else $error("timer or output moved in sleep");

	property p_reset_state;
		@(posedge REF_CLK)
		!RST_B |=> PWM_OE_B && !ctrl_reg.en && state_reg == ST_IDLE &&
			period_reg == PERIOD_RST;
	endproperty
	a_reset_state: assert property (p_reset_state)
		else $error("reset did not restore registers");

	property p_readback;
		@(posedge REF_CLK) disable iff (!RST_B)
		(accept && !HWRITE && HADDR[7:0] == OFS_CTRL)
			|=> HRDATA[CTRL_OUT_BIT] == $past(PWM_OUT);
	endproperty
	a_readback: assert property (p_readback)
		else $error("output level readback wrong");

endmodule
`default_nettype wire

// ### dv/pwm_load.sv
// External load on the PWM pin: measures period and high time
`timescale 1ns/1ps
`default_nettype none
module pwm_load (
	input wire logic clk,
	input wire logic pin,
	input wire logic oe_b,
	output logic [15:0] per_len,
	output logic [15:0] hi_len
);
	logic lvl;
	logic prev_reg = 1'b0;
	logic [15:0] per_cnt = 16'h0000;
	logic [15:0] hi_cnt = 16'h0000;
	// Pull-down on the line: a released pin reads low, never its last value
	assign lvl = oe_b ? 1'b0 : pin;
	// ----------------------------------------------------------------
	// Rise to rise is one period; high samples in between are the width
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		prev_reg <= lvl;
		if (lvl && !prev_reg) begin
			per_len <= per_cnt;
			hi_len <= hi_cnt;
			per_cnt <= 16'h0001;
			hi_cnt <= 16'h0001;
		end else begin
			per_cnt <= per_cnt + 16'h0001;
			hi_cnt <= hi_cnt + 16'(lvl);
		end
	end
endmodule
`default_nettype wire

// ### dv/testbench.sv
// Self-checking bench for the ten-bit PWM generator
`timescale 1ns/1ps
`default_nettype none
module testbench
	import pwm_pkg::*;
;
	logic REF_CLK = 1'b0;
	logic RST_B = 1'b0;
	logic HSEL = 1'b0;
	logic [31:0] HADDR = 32'h0;
	logic [1:0] HTRANS = 2'h0;
	logic HWRITE = 1'b0;
	logic [31:0] HWDATA = 32'h0;
	logic SLEEP_REQ = 1'b0;
	logic [31:0] HRDATA;
	logic HREADYOUT;
	logic HRESP;
	logic PWM_OUT;
	logic PWM_OE_B;
	logic [15:0] per_len;
	logic [15:0] hi_len;
	int errors = 0;
	int n_checks = 0;
	logic [7:0] ra [9] = '{OFS_CTRL, OFS_DUTY_HI, OFS_DUTY_LO, OFS_PERIOD,
		OFS_TMR_CTRL, OFS_TMR_COUNT, OFS_FLAGS, OFS_PIN, 8'h40};
	logic [7:0] rv [9] = '{8'h00, DUTY_RST, DUTY_RST, PERIOD_RST, 8'h00,
		TMR_RST, 8'h00, {7'h00, PIN_DIR_RST}, 8'h00};

	pwm_top uut (.REF_CLK(REF_CLK), .RST_B(RST_B), .HSEL(HSEL),
		.HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2),
		.HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
		.HREADYOUT(HREADYOUT), .HRESP(HRESP), .SLEEP_REQ(SLEEP_REQ),
		.PWM_OUT(PWM_OUT), .PWM_OE_B(PWM_OE_B));
	pwm_load load (.clk(REF_CLK), .pin(PWM_OUT), .oe_b(PWM_OE_B),
		.per_len(per_len), .hi_len(hi_len));

	always #2 REF_CLK = ~REF_CLK;

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic check(input string n, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	// ----------------------------------------------------------------
	// AHB-Lite single word transfers; waits on ready at each phase
	// ----------------------------------------------------------------
	task automatic xfer(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HWRITE <= wr;
		HADDR <= {24'h0, a};
		do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
		HTRANS <= 2'h0;
		HSEL <= 1'b0;
		HWDATA <= wd;
		do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
		rd = HRDATA;
		check("hresp", 32'h0, 32'(HRESP));
		check("hready", 32'h1, 32'(HREADYOUT));
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] x;
		xfer(1'b1, a, {24'h0, d}, x);
	endtask

	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		logic [31:0] x;
		xfer(1'b0, a, 32'h0, x);
		check("reg_read", {24'h0, e}, x);
	endtask

	task automatic lvl_chk(input logic e, input int n);
		logic s;
		s = e;
		for (int i = 0; i < n; i++) begin
			@(posedge REF_CLK);
			if (PWM_OUT !== e) s = PWM_OUT;
		end
		check("pwm_level", 32'(e), 32'(s));
	endtask

	task automatic wait_rise();
		logic p;
		p = PWM_OUT;
		for (int i = 0; i < 5000; i++) begin
			@(posedge REF_CLK);
			if (PWM_OUT === 1'b1 && p === 1'b0) break;
			p = PWM_OUT;
		end
		repeat (2) @(posedge REF_CLK);
	endtask

	task automatic meas(input int per, input int hi);
		check("period", 32'(per), 32'(per_len));
		check("width", 32'(hi), 32'(hi_len));
	endtask

	initial begin
		repeat (60000) @(posedge REF_CLK);
		errors++;
		end_of_test();
	end

	initial begin
		logic [31:0] x;
		logic [7:0] c;
		logic o;
		int m;
		repeat (10) @(posedge REF_CLK);
		RST_B <= 1'b1;
		@(posedge REF_CLK);
		for (int i = 0; i < 9; i++) rc(ra[i], rv[i]);
		check("oe_b", 32'h1, 32'(PWM_OE_B));
		check("out", 32'h0, 32'(PWM_OUT));
		$display("test reset done");
		// Setup order for a complete first period
		wr(OFS_PIN, 8'h01);
		wr(OFS_CTRL, 8'h00);
		wr(OFS_PERIOD, 8'h03);
		wr(OFS_DUTY_HI, 8'h02);
		wr(OFS_DUTY_LO, 8'hbf);
		rc(OFS_DUTY_LO, 8'h80);
		wr(OFS_FLAGS, 8'h01);
		wr(OFS_TMR_CTRL, 8'h04);
		for (int i = 0; i < 50; i++) begin
			xfer(1'b0, OFS_FLAGS, 32'h0, x);
			if (x[FLAG_MATCH_BIT] === 1'b1) break;
		end
		check("match_flag", 32'h1, x);
		wr(OFS_PIN, 8'h00);
		wr(OFS_CTRL, 8'h80);
		check("oe_b", 32'h0, 32'(PWM_OE_B));
		$display("test setup done");
		for (int p = 0; p < 4; p++) begin
			m = 1 << (2 * p);
			wr(OFS_TMR_CTRL, 8'h04 | 8'(p));
			repeat (48 * m + 8) @(posedge REF_CLK);
			meas(16 * m, 10 * m);
			xfer(1'b0, OFS_TMR_COUNT, 32'h0, x);
			check("count_in_range", 32'h1, 32'(x <= 32'h3));
		end
		wr(OFS_TMR_CTRL, 8'h04);
		$display("test prescale done");
		wait_rise();
		wr(OFS_DUTY_HI, 8'h03);
		wait_rise();
		meas(16, 10);
		wait_rise();
		meas(16, 14);
		$display("test double buffer done");
		wr(OFS_CTRL, 8'h90);
		repeat (60) @(posedge REF_CLK);
		meas(16, 2);
		wr(OFS_CTRL, 8'h10);
		// Disable reaches the pin two clocks after the write lands
		repeat (2) @(posedge REF_CLK);
		lvl_chk(1'b1, 40);
		wr(OFS_CTRL, 8'h00);
		repeat (2) @(posedge REF_CLK);
		lvl_chk(1'b0, 40);
		$display("test polarity done");
		wr(OFS_CTRL, 8'h80);
		wr(OFS_DUTY_HI, 8'h00);
		wr(OFS_DUTY_LO, 8'h00);
		repeat (20) @(posedge REF_CLK);
		lvl_chk(1'b0, 40);
		rc(OFS_CTRL, 8'h80);
		wr(OFS_DUTY_HI, 8'hff);
		wr(OFS_DUTY_LO, 8'hc0);
		repeat (20) @(posedge REF_CLK);
		lvl_chk(1'b1, 40);
		rc(OFS_CTRL, 8'ha0);
		$display("test duty limits done");
		wr(OFS_DUTY_HI, 8'h02);
		wr(OFS_DUTY_LO, 8'h80);
		repeat (40) @(posedge REF_CLK);
		SLEEP_REQ <= 1'b1;
		repeat (5) @(posedge REF_CLK);
		xfer(1'b0, OFS_TMR_COUNT, 32'h0, x);
		c = x[7:0];
		o = PWM_OUT;
		lvl_chk(o, 50);
		rc(OFS_TMR_COUNT, c);
		SLEEP_REQ <= 1'b0;
		repeat (60) @(posedge REF_CLK);
		meas(16, 10);
		$display("test sleep done");
		wr(OFS_PERIOD, 8'hff);
		wr(OFS_DUTY_LO, 8'h40);
		wr(OFS_DUTY_HI, 8'hff);
		repeat (3100) @(posedge REF_CLK);
		meas(1024, 1021);
		$display("test resolution done");
		RST_B <= 1'b0;
		repeat (2) @(posedge REF_CLK);
		RST_B <= 1'b1;
		@(posedge REF_CLK);
		check("oe_b", 32'h1, 32'(PWM_OE_B));
		check("out", 32'h0, 32'(PWM_OUT));
		rc(OFS_PERIOD, PERIOD_RST);
		rc(OFS_CTRL, 8'h00);
		$display("test second reset done");
		end_of_test();
	end
endmodule
`default_nettype wire
